// file: gpei_pkg.sv
// Purpose: Shared constants and types for the port pin interrupt block.
// Assumes: One clock, ref_clk at 250 MHz, synchronous active-low reset.
// Notes: Register offsets are byte addresses of 32-bit words.
package gpei_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPORT = 2;
  localparam int PINS = 8;
  localparam int NPIN = NPORT * PINS;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int PORT_SHIFT = 5;
  localparam int FILT_LEN = 3;
  localparam int FILT_CW = 2;
  localparam int NSRC = NPORT + 2;

  // ----------------------------------------------------------------
  // Device registers, per port at base port << PORT_SHIFT, except SUMMARY and SYSCTL
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [AW-1:0] OFS_FORCE = 8'h04;
  localparam logic [AW-1:0] OFS_ENABLE = 8'h08;
  localparam logic [AW-1:0] OFS_MASKED = 8'h0c;
  localparam logic [AW-1:0] OFS_CONFIG = 8'h10;
  localparam logic [AW-1:0] OFS_PADCFG = 8'h14;
  localparam logic [AW-1:0] OFS_SUMMARY = 8'h40;
  localparam logic [AW-1:0] OFS_SYSCTL = 8'h44;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_FILT_FLAG = 8;
  localparam int ST_LEVEL_LSB = 16;
  localparam int ST_FILT_LEVEL = 24;
  localparam int CFG_FILT_EDGE_LSB = 16;
  localparam int CFG_FILT_SRC_LSB = 18;
  localparam int CFG_W = 21;
  localparam int PAD_DIG_LSB = 8;
  localparam int SYS_DBG_RELEASE = 0;
  localparam int SYS_SYNC_SEL = 1;

  // ----------------------------------------------------------------
  // Debug pin reset value and fixed pin masks
  // ----------------------------------------------------------------
  localparam logic [NPIN-1:0] DBG_PIN_MASK = 16'h0003;
  localparam logic [NPIN-1:0] DS_CAPABLE_MASK = 16'h00f0;
  localparam logic [NPIN-1:0] HIB_WAKE_MASK = 16'h0101;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] C_ACCESS = 8'h00;
  localparam logic [AW-1:0] C_WDATA = 8'h04;
  localparam logic [AW-1:0] C_RDATA = 8'h08;
  localparam logic [AW-1:0] C_MODE = 8'h0c;
  localparam logic [AW-1:0] C_PENDING = 8'h10;
  localparam logic [AW-1:0] C_FAB_SEL = 8'h14;
  localparam int ACC_WR_BIT = 8;
  localparam int ACC_RD_BIT = 9;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } gpei_edge_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_DEEP = 2'h2,
    PWR_HIB = 2'h3
  } gpei_pwr_t;

endpackage

// file: gpei_if.sv
// Purpose: Carrier between the port interrupt device and its controller.
// Assumes: Both ends run on the same ref_clk.
// Notes: Register access is a plain strobe port, read data one cycle later.
`timescale 1ns/1ns
interface gpei_if;
  logic [gpei_pkg::AW-1:0] reg_addr;
  logic [gpei_pkg::DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [gpei_pkg::DW-1:0] reg_rdata;
  logic [gpei_pkg::NPORT-1:0] port_irq;
  logic shared_irq;
  logic [gpei_pkg::NPIN-1:0] fabric_data;

  modport dev (
    input reg_addr,
    input reg_wdata,
    input reg_wr,
    input reg_rd,
    output reg_rdata,
    output port_irq,
    output shared_irq,
    output fabric_data
  );

  modport ctl (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input reg_rdata,
    input port_irq,
    input shared_irq,
    input fabric_data
  );
endinterface

// file: gpei_port_irq.sv
// Purpose: Per-port pin edge interrupt logic with pad state control.
// Assumes: Pad levels, boot flag and sync strobe are asynchronous inputs.
// Notes: Power mode comes from logic on ref_clk.
`timescale 1ns/1ns
module gpei_port_irq (
  input wire logic ref_clk,
  input wire logic rst_n,
  gpei_if.dev link,
  input wire logic [gpei_pkg::NPIN-1:0] pad_level_in,
  input wire logic [1:0] power_mode,
  input wire logic boot_done,
  input wire logic sync_strobe_in,
  output logic [gpei_pkg::NPIN-1:0] pad_input_en,
  output logic [gpei_pkg::NPIN-1:0] pad_analog_hiz,
  output logic [gpei_pkg::NPIN-1:0] pad_freeze,
  output logic [gpei_pkg::NPIN-1:0] debug_pin_active
);
  localparam int NP = gpei_pkg::NPORT;
  localparam int PN = gpei_pkg::PINS;
  localparam int NPIN = gpei_pkg::NPIN;
  // ----------------------------------------------------------------
  // Input synchronisers and storage
  // ----------------------------------------------------------------
  logic [NPIN-1:0] pad_meta_reg, pad_sync_reg, level_prev_reg;
  logic [1:0] misc_meta_reg, misc_sync_reg;
  logic strobe_prev_reg;
  logic [NPIN-1:0] level;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
      misc_meta_reg <= '0;
      misc_sync_reg <= '0;
    end else begin
      pad_meta_reg <= pad_level_in;
      pad_sync_reg <= pad_meta_reg;
      misc_meta_reg <= {sync_strobe_in, boot_done};
      misc_sync_reg <= misc_meta_reg;
    end
  end
  // An input buffer that is off reads low.
  assign level = pad_sync_reg & pad_input_en;
  logic [PN:0] status_reg [NP];
  logic [PN:0] status_next [NP];
  logic [PN:0] enable_reg [NP];
  logic [gpei_pkg::CFG_W-1:0] cfg_reg [NP];
  logic [1:0] sysctl_reg;
  logic [NP-1:0] port_irq_reg;
  logic shared_irq_reg;
  logic [gpei_pkg::DW-1:0] rdata_reg, rd_val;
  logic [NPIN-1:0] fabric_data_reg;
  logic [NPIN-1:0] pad_input_en_reg, pad_analog_hiz_reg, pad_freeze_reg;
  logic [NPIN-1:0] debug_pin_active_reg, wake_ok;
  logic [NP-1:0] filt_level_reg, filt_prev_reg, filt_src;
  logic [gpei_pkg::FILT_CW-1:0] filt_cnt_reg [NP];
  assign wake_ok = {NPIN{power_mode != gpei_pkg::PWR_HIB}}
    | gpei_pkg::HIB_WAKE_MASK;
  function automatic logic hit_at(int p, logic [gpei_pkg::AW-1:0] ofs);
    hit_at = link.reg_addr == gpei_pkg::AW'((p << gpei_pkg::PORT_SHIFT)
      + int'(ofs));
  endfunction
  function automatic logic edge_hit(logic [1:0] sel, logic now, logic was);
    case (gpei_pkg::gpei_edge_t'(sel))
      gpei_pkg::EDGE_RISE: edge_hit = now & ~was;
      gpei_pkg::EDGE_FALL: edge_hit = ~now & was;
      gpei_pkg::EDGE_BOTH: edge_hit = now ^ was;
      default: edge_hit = 1'b0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Edge detection and status flags
  // ----------------------------------------------------------------
  always_comb begin
    logic [PN:0] set_v, clr_v, frc_v;
    int n;
    int s;
    set_v = '0;
    clr_v = '0;
    frc_v = '0;
    n = 0;
    s = 0;
    for (int p = 0; p < NP; p++) begin
      for (int i = 0; i < PN; i++) begin
        n = p * PN + i;
        set_v[i] = edge_hit(cfg_reg[p][2*i +: 2], level[n],
          level_prev_reg[n]) & wake_ok[n];
      end
      s = p * PN + int'(cfg_reg[p][gpei_pkg::CFG_FILT_SRC_LSB +: 3]);
      filt_src[p] = level[s];
      set_v[PN] = edge_hit(cfg_reg[p][gpei_pkg::CFG_FILT_EDGE_LSB +: 2],
        filt_level_reg[p], filt_prev_reg[p]) & wake_ok[s];
      clr_v = (link.reg_wr && hit_at(p, gpei_pkg::OFS_STATUS)) ?
        link.reg_wdata[PN:0] : '0;
      frc_v = (link.reg_wr && hit_at(p, gpei_pkg::OFS_FORCE)) ?
        link.reg_wdata[PN:0] : '0;
      // A new edge or force beats a clear in the same cycle.
      status_next[p] = (status_reg[p] & ~clr_v)
        | set_v | frc_v;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_prev_reg <= '0;
      status_reg <= '{default: '0};
    end else begin
      level_prev_reg <= level;
      status_reg <= status_next;
    end
  end
  // ----------------------------------------------------------------
  // Glitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filt_level_reg <= '0;
      filt_prev_reg <= '0;
      filt_cnt_reg <= '{default: '0};
    end else begin
      filt_prev_reg <= filt_level_reg;
      for (int p = 0; p < NP; p++) begin
        if (filt_src[p] == filt_level_reg[p]) begin
          filt_cnt_reg[p] <= '0;
        end else if (filt_cnt_reg[p] ==
            gpei_pkg::FILT_CW'(gpei_pkg::FILT_LEN - 1)) begin
          filt_level_reg[p] <= filt_src[p];
          filt_cnt_reg[p] <= '0;
        end else begin
          filt_cnt_reg[p] <= filt_cnt_reg[p] + 1'b1;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sysctl_reg <= '0;
      enable_reg <= '{default: '0};
      cfg_reg <= '{default: '0};
    end else if (link.reg_wr) begin
      if (link.reg_addr == gpei_pkg::OFS_SYSCTL) begin
        sysctl_reg <= link.reg_wdata[1:0];
      end
      for (int p = 0; p < NP; p++) begin
        if (hit_at(p, gpei_pkg::OFS_ENABLE)) begin
          enable_reg[p] <= link.reg_wdata[PN:0];
        end
        if (hit_at(p, gpei_pkg::OFS_CONFIG)) begin
          cfg_reg[p] <= link.reg_wdata[gpei_pkg::CFG_W-1:0];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Pad state, freezing and debug pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pad_input_en_reg <= '0;
      pad_analog_hiz_reg <= '1;
      pad_freeze_reg <= '0;
      debug_pin_active_reg <= gpei_pkg::DBG_PIN_MASK;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        pad_freeze_reg[i] <= (power_mode == gpei_pkg::PWR_HIB)
          | ((power_mode == gpei_pkg::PWR_DEEP)
          & ~gpei_pkg::DS_CAPABLE_MASK[i]);
        if (link.reg_wr && !pad_freeze_reg[i]
            && hit_at(i / PN, gpei_pkg::OFS_PADCFG)) begin
          pad_input_en_reg[i] <= link.reg_wdata[i % PN];
          pad_analog_hiz_reg[i] <=
            ~link.reg_wdata[gpei_pkg::PAD_DIG_LSB + i % PN];
        end
      end
      if (sysctl_reg[gpei_pkg::SYS_DBG_RELEASE] && misc_sync_reg[0]) begin
        debug_pin_active_reg <= '0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Fabric synchronisation, interrupt lines and read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strobe_prev_reg <= 1'b0;
      fabric_data_reg <= '0;
      port_irq_reg <= '0;
      shared_irq_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= misc_sync_reg[1];
      if (!sysctl_reg[gpei_pkg::SYS_SYNC_SEL]
          || (misc_sync_reg[1] && !strobe_prev_reg)) begin
        fabric_data_reg <= level;
      end
      for (int p = 0; p < NP; p++) begin
        port_irq_reg[p] <= |(status_reg[p] & enable_reg[p]);
      end
      shared_irq_reg <= |port_irq_reg;
    end
  end
  always_comb begin
    rd_val = '0;
    if (link.reg_addr == gpei_pkg::OFS_SUMMARY) begin
      rd_val[NP-1:0] = port_irq_reg;
    end
    if (link.reg_addr == gpei_pkg::OFS_SYSCTL) begin
      rd_val[1:0] = sysctl_reg;
    end
    for (int p = 0; p < NP; p++) begin
      if (hit_at(p, gpei_pkg::OFS_STATUS) || hit_at(p, gpei_pkg::OFS_FORCE))
          begin
        rd_val[PN:0] = status_reg[p];
        rd_val[gpei_pkg::ST_LEVEL_LSB +: PN] = level[p*PN +: PN];
        rd_val[gpei_pkg::ST_FILT_LEVEL] = filt_level_reg[p];
      end
      if (hit_at(p, gpei_pkg::OFS_ENABLE)) begin
        rd_val[PN:0] = enable_reg[p];
      end
      if (hit_at(p, gpei_pkg::OFS_MASKED)) begin
        rd_val[PN:0] = status_reg[p] & enable_reg[p];
      end
      if (hit_at(p, gpei_pkg::OFS_CONFIG)) begin
        rd_val[gpei_pkg::CFG_W-1:0] = cfg_reg[p];
      end
      if (hit_at(p, gpei_pkg::OFS_PADCFG)) begin
        rd_val[PN-1:0] = pad_input_en_reg[p*PN +: PN];
        rd_val[gpei_pkg::PAD_DIG_LSB +: PN] = ~pad_analog_hiz_reg[p*PN +: PN];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !link.reg_rd) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_val;
    end
  end
  assign link.reg_rdata = rdata_reg;
  assign link.port_irq = port_irq_reg;
  assign link.shared_irq = shared_irq_reg;
  assign link.fabric_data = fabric_data_reg;
  assign pad_input_en = pad_input_en_reg;
  assign pad_analog_hiz = pad_analog_hiz_reg;
  assign pad_freeze = pad_freeze_reg;
  assign debug_pin_active = debug_pin_active_reg;
endmodule // gpei_port_irq

// file: gpei_irq_ctl.sv
// Purpose: Interrupt source multiplexer and register access master.
// Assumes: Software drives the plain port on ref_clk.
// Notes: Sources are port lines, the shared line and one fabric pin.
`timescale 1ns/1ns
module gpei_irq_ctl (
  input wire logic ref_clk,
  input wire logic rst_n,
  gpei_if.ctl link,
  input wire logic [gpei_pkg::AW-1:0] sw_addr,
  input wire logic [gpei_pkg::DW-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [gpei_pkg::DW-1:0] sw_rdata,
  output logic cpu_irq
);

  localparam int NS = gpei_pkg::NSRC;

  // ----------------------------------------------------------------
  // Device access master
  // ----------------------------------------------------------------
  logic [gpei_pkg::AW-1:0] dev_addr_reg;
  logic [gpei_pkg::DW-1:0] dev_wdata_reg, dev_result_reg;
  logic dev_wr_reg, dev_rd_reg, dev_rd_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dev_addr_reg <= '0;
      dev_wdata_reg <= '0;
      dev_wr_reg <= 1'b0;
      dev_rd_reg <= 1'b0;
      dev_rd_prev_reg <= 1'b0;
      dev_result_reg <= '0;
    end else begin
      dev_wr_reg <= 1'b0;
      dev_rd_reg <= 1'b0;
      dev_rd_prev_reg <= dev_rd_reg;
      if (dev_rd_prev_reg) begin
        dev_result_reg <= link.reg_rdata;
      end
      if (sw_wr && sw_addr == gpei_pkg::C_WDATA) begin
        dev_wdata_reg <= sw_wdata;
      end
      if (sw_wr && sw_addr == gpei_pkg::C_ACCESS) begin
        dev_addr_reg <= sw_wdata[gpei_pkg::AW-1:0];
        // Status clears travel this path and act on one-bits.
        dev_wr_reg <= sw_wdata[gpei_pkg::ACC_WR_BIT];
        dev_rd_reg <= sw_wdata[gpei_pkg::ACC_RD_BIT] &
          ~sw_wdata[gpei_pkg::ACC_WR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Source multiplexer
  // ----------------------------------------------------------------
  logic [NS-1:0] mode_reg, src, src_prev_reg, pending_reg, latch_reg, clr;
  logic [3:0] fab_sel_reg;
  logic cpu_irq_reg;
  logic [gpei_pkg::DW-1:0] sw_rdata_reg;

  always_comb begin
    src = {link.fabric_data[fab_sel_reg], link.shared_irq,
      link.port_irq};
    clr = (sw_wr && sw_addr == gpei_pkg::C_PENDING) ?
      sw_wdata[NS-1:0] : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_reg <= '1;
      fab_sel_reg <= '0;
      src_prev_reg <= '0;
      latch_reg <= '0;
      pending_reg <= '0;
      cpu_irq_reg <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == gpei_pkg::C_MODE) begin
        mode_reg <= sw_wdata[NS-1:0];
      end
      if (sw_wr && sw_addr == gpei_pkg::C_FAB_SEL) begin
        fab_sel_reg <= sw_wdata[3:0];
      end
      src_prev_reg <= src;
      // A rise in the clear cycle is kept.
      latch_reg <= (latch_reg & ~clr) | (src & ~src_prev_reg);
      for (int k = 0; k < NS; k++) begin
        pending_reg[k] <= mode_reg[k] ? latch_reg[k] : src[k];
      end
      cpu_irq_reg <= |pending_reg;
    end
  end

  // ----------------------------------------------------------------
  // Software read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_rdata_reg <= '0;
    end else begin
      sw_rdata_reg <= '0;
      if (sw_rd) begin
        case (sw_addr)
          gpei_pkg::C_ACCESS: sw_rdata_reg[gpei_pkg::AW-1:0] <= dev_addr_reg;
          gpei_pkg::C_WDATA: sw_rdata_reg <= dev_wdata_reg;
          gpei_pkg::C_RDATA: sw_rdata_reg <= dev_result_reg;
          gpei_pkg::C_MODE: sw_rdata_reg[NS-1:0] <= mode_reg;
          gpei_pkg::C_PENDING: sw_rdata_reg[NS-1:0] <= pending_reg;
          gpei_pkg::C_FAB_SEL: sw_rdata_reg[3:0] <= fab_sel_reg;
          default: sw_rdata_reg <= '0;
        endcase
      end
    end
  end

  assign link.reg_addr = dev_addr_reg;
  assign link.reg_wdata = dev_wdata_reg;
  assign link.reg_wr = dev_wr_reg;
  assign link.reg_rd = dev_rd_reg;
  assign sw_rdata = sw_rdata_reg;
  assign cpu_irq = cpu_irq_reg;

endmodule // gpei_irq_ctl

// file: gpei_checker.sv
// Purpose: Interface checker for the port interrupt carrier.
// Assumes: One ref_clk, synchronous active-low rst_n.
// Notes: Tracks the port 0 enable bits to judge forwarding.
`timescale 1ns/1ns
module gpei_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] port_irq,
  input wire logic shared_irq,
  input wire logic [15:0] fabric_data
);
  logic [8:0] en0_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en0_reg <= 9'h000;
    end else if (reg_wr && reg_addr == 8'h08) begin
      en0_reg <= reg_wdata[8:0];
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_shared_or: assert property (shared_irq == |$past(port_irq))
    else $error("shared line is not the OR of port lines");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data present without a read");
  a_clear_drop: assert property (reg_wr && reg_addr == 8'h00 &&
    reg_wdata[8:0] == 9'h1ff |-> ##2 !port_irq[0])
    else $error("port line stayed up after clear");
  a_force_raise: assert property (reg_wr && reg_addr == 8'h04 &&
    (reg_wdata[8:0] & en0_reg) != 9'h0 |-> ##2 port_irq[0])
    else $error("force did not raise the port line");
  a_mask_block: assert property (port_irq[0] |-> $past(en0_reg) != 9'h0)
    else $error("port line up with all enables off");
  a_masked_gate: assert property (reg_rd && reg_addr == 8'h0c |=>
    (reg_rdata[8:0] & ~$past(en0_reg)) == 9'h0)
    else $error("masked view shows a disabled pin");
  a_summary_view: assert property (reg_rd && reg_addr == 8'h40
    |=> reg_rdata[1:0] == $past(port_irq))
    else $error("summary differs from port lines");
  a_flag_hold: assert property (($past(port_irq) & ~port_irq) != 2'h0
    |-> $past(reg_wr, 2))
    else $error("port line fell without a write");
endmodule // gpei_checker

// file: gpio_port_edge_interrupt_test.sv
// Purpose: Self-checking bench for both ends of the port interrupt block.
// Assumes: ref_clk at 250 MHz, reset held for 3 cycles.
// Notes: Device registers are reached through the controller.
`timescale 1ns/1ns
module gpio_port_edge_interrupt_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] pad = 16'h0000;
  logic [1:0] pmode = 2'h0;
  logic boot_done = 1'b0;
  logic strobe = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata, d;
  logic cpu_irq;
  logic [15:0] in_en, hiz, frz, dbg;
  int err_total = 0;
  int comparisons = 0;
  int m;
  gpei_if link ();
  always #2 ref_clk = ~ref_clk;
  gpei_port_irq u_gpei_port_irq (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link.dev), .pad_level_in(pad), .power_mode(pmode),
    .boot_done(boot_done), .sync_strobe_in(strobe), .pad_input_en(in_en),
    .pad_analog_hiz(hiz), .pad_freeze(frz), .debug_pin_active(dbg));
  gpei_irq_ctl u_gpei_irq_ctl (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link.ctl), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cpu_irq(cpu_irq));
  gpei_checker u_gpei_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .port_irq(link.port_irq), .shared_irq(link.shared_irq),
    .fabric_data(link.fabric_data));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic swr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic srd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  task automatic dwr(input logic [7:0] a, input logic [31:0] v);
    swr(8'h04, v);
    swr(8'h00, {23'h0, 1'b1, a});
  endtask
  task automatic drd(input logic [7:0] a, output logic [31:0] v);
    swr(8'h00, {22'h0, 2'b10, a});
    repeat (3) @(posedge ref_clk);
    srd(8'h08, v);
  endtask
  task automatic summarize;
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    summarize;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk("hiz", 16'hffff, hiz);
    chk("inen", 16'h0000, in_en);
    chk("dbg", 16'h0003, dbg);
    dwr(8'h14, 32'h0000ffff);
    dwr(8'h34, 32'h0000ffff);
    dwr(8'h08, 32'h000001ff);
    dwr(8'h28, 32'h000001ff);
    chk("inen", 16'hffff, in_en);
    chk("hiz", 16'h0000, hiz);
    for (m = 0; m < 4; m++) begin
      dwr(8'h10, {16'h0, {8{m[1:0]}}});
      pad[0] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      drd(8'h00, d);
      chk("rise", {30'h0, m[0], 1'b1}, {30'h0, d[0], d[16]});
      drd(8'h40, d);
      chk("sum", {31'h0, m[0]}, {30'h0, d[1:0]});
      dwr(8'h00, 32'h000001ff);
      pad[0] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      drd(8'h00, d);
      chk("fall", {30'h0, m[1], 1'b0}, {30'h0, d[0], d[16]});
      dwr(8'h00, 32'h000001ff);
      drd(8'h00, d);
      chk("clr", 32'h0, {31'h0, d[0]});
    end
    dwr(8'h08, 32'h000000fe);
    dwr(8'h04, 32'h00000001);
    drd(8'h00, d);
    chk("force", 32'h1, {31'h0, d[0]});
    drd(8'h0c, d);
    chk("masked", 32'h0, {23'h0, d[8:0]});
    drd(8'h40, d);
    chk("sum0", 32'h0, {30'h0, d[1:0]});
    swr(8'h10, 32'h0000000f);
    repeat (3) @(posedge ref_clk);
    chk("cpu", 32'h0, {31'h0, cpu_irq});
    dwr(8'h08, 32'h000001ff);
    dwr(8'h04, 32'h00000002);
    drd(8'h0c, d);
    chk("masked", 32'h3, {23'h0, d[8:0]});
    chk("cpu", 32'h1, {31'h0, cpu_irq});
    swr(8'h0c, 32'h0000000e);
    swr(8'h10, 32'h0000000f);
    srd(8'h10, d);
    chk("level", 32'h1, d);
    dwr(8'h00, 32'h000001ff);
    repeat (3) @(posedge ref_clk);
    srd(8'h10, d);
    chk("level", 32'h0, d);
    dwr(8'h30, 32'h00150000);
    pad[13] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    drd(8'h20, d);
    chk("filt", 32'h700, {21'h0, d[24], d[21], d[8:0]});
    dwr(8'h20, 32'h000001ff);
    dwr(8'h30, 32'h00170000);
    pad[13] <= 1'b0;
    @(posedge ref_clk);
    pad[13] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    drd(8'h20, d);
    chk("glitch", 32'h0, {31'h0, d[8]});
    chk("fab", {16'h0, pad}, {16'h0, link.fabric_data});
    dwr(8'h44, 32'h00000002);
    pad[13] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("hold", {16'h0, pad ^ 16'h2000}, {16'h0, link.fabric_data});
    strobe <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("fab", {16'h0, pad}, {16'h0, link.fabric_data});
    for (m = 0; m < 4; m++) begin
      pmode <= m[1:0];
      repeat (2) @(posedge ref_clk);
      chk("frz", (m == 3) ? 16'hffff : (m == 2) ? 16'hff0f : 16'h0,
          frz);
    end
    chk("inen", 16'hffff, in_en);
    pad[1:0] <= 2'b11;
    repeat (6) @(posedge ref_clk);
    drd(8'h00, d);
    chk("hib", 32'h1, {30'h0, d[1:0]});
    pmode <= 2'h0;
    dwr(8'h44, 32'h00000001);
    boot_done <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("dbg", 16'h0000, dbg);
    summarize;
  end
endmodule // gpio_port_edge_interrupt_test
